/* File: design/iwd_cfg.svh */
`ifndef IWD_CFG_SVH
`define IWD_CFG_SVH

// instruction word geometry
`define IWD_WORD_W        14
`define IWD_FILE_W        7
`define IWD_FILE_MAX      7'h7f
`define IWD_BITPOS_LSB    7
`define IWD_DEST_BIT      7
`define IWD_PTR_SLOT_BIT  6
`define IWD_PTR_SLOT_INC  2
// immediate widths
`define IWD_K8_W          8
`define IWD_K11_W         11
`define IWD_K7_W          7
`define IWD_K5_W          5
`define IWD_K9_W          9
`define IWD_K6_W          6
// timing
`define IWD_OSC_PER_ICYC  4
`define IWD_BASE_CYCLES   2'h1

`endif

/* File: design/iwd_pkg.sv */
`default_nettype none
package iwd_pkg;

   typedef enum logic [4:0] {
      IWD_OP_NOP        = 5'h00,
      IWD_OP_BYTE       = 5'h01,
      IWD_OP_BYTE_SKIP  = 5'h02,
      IWD_OP_BIT        = 5'h03,
      IWD_OP_BIT_SKIP_C = 5'h04,
      IWD_OP_BIT_SKIP_S = 5'h05,
      IWD_OP_LITERAL    = 5'h06,
      IWD_OP_SUB_JUMP   = 5'h07,
      IWD_OP_ABS_JUMP   = 5'h08,
      IWD_OP_PAGE_LOAD  = 5'h09,
      IWD_OP_BANK_LOAD  = 5'h0a,
      IWD_OP_REL_JUMP   = 5'h0b,
      IWD_OP_PTR_OFFSET = 5'h0c,
      IWD_OP_PTR_STEP   = 5'h0d,
      IWD_OP_CSUB_JUMP  = 5'h0e,
      IWD_OP_SUB_EXIT   = 5'h0f,
      IWD_OP_EXIT_LIT   = 5'h10,
      IWD_OP_INT_EXIT   = 5'h11,
      IWD_OP_ACC_JUMP   = 5'h12,
      IWD_OP_MOVE_W     = 5'h13,
      IWD_OP_CLEAR      = 5'h14,
      IWD_OP_CONTROL    = 5'h15
   } iwd_class_t;

   typedef enum logic [1:0] {
      IWD_ST_IDLE  = 2'b00,
      IWD_ST_READ  = 2'b01,
      IWD_ST_EXTRA = 2'b10,
      IWD_ST_WRITE = 2'b11
   } iwd_state_t;

   typedef struct packed {
      iwd_class_t  op_class;
      logic        uses_file;
      logic        target_sel;
      logic [6:0]  reg_index;
      logic [2:0]  pos_in_octet;
      logic        ptr_slot;
      logic [1:0]  ptr_step;
      logic [10:0] literal;
      logic [1:0]  base_cycles;
      logic        branch_on_skip;
   } iwd_fields_t;

endpackage
`default_nettype wire

/* File: design/iwd_field_split.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iwd_cfg.svh"

module iwd_field_split
   import iwd_pkg::*;
(
   input  wire logic [13:0] word_i,
   output iwd_fields_t      fields_o
);

   logic [1:0] cls2;
   logic [3:0] op4;

   assign cls2 = word_i[13:12];
   assign op4  = word_i[11:8];

   always_comb begin
      fields_o                = '0;
      fields_o.op_class       = IWD_OP_NOP;
      fields_o.target_sel     = word_i[`IWD_DEST_BIT];
      fields_o.reg_index      = word_i[`IWD_FILE_W-1:0];
      fields_o.pos_in_octet   = word_i[9:`IWD_BITPOS_LSB];
      fields_o.ptr_slot       = word_i[`IWD_PTR_SLOT_BIT];
      fields_o.ptr_step       = word_i[1:0];
      fields_o.base_cycles    = `IWD_BASE_CYCLES;
      case (cls2)
         2'b00: begin
            fields_o.uses_file = 1'b1;
            fields_o.op_class  = IWD_OP_BYTE;
            if (op4 == 4'hb || op4 == 4'hf) begin
               fields_o.op_class       = IWD_OP_BYTE_SKIP;
               fields_o.branch_on_skip = 1'b1;
            end else if (op4 == 4'h1) begin
               fields_o.op_class   = IWD_OP_CLEAR;
               fields_o.uses_file  = word_i[7];
               fields_o.target_sel = word_i[7];
            end else if (op4 == 4'h0) begin
               fields_o.uses_file = 1'b0;
               if (word_i[7]) begin
                  fields_o.op_class   = IWD_OP_MOVE_W;
                  fields_o.uses_file  = 1'b1;
                  fields_o.target_sel = 1'b1;
               end else if (word_i[6:5] == 2'b01) begin
                  fields_o.op_class = IWD_OP_BANK_LOAD;
                  fields_o.literal  = {6'h00, word_i[`IWD_K5_W-1:0]};
               end else if (word_i[6:4] == 3'b001) begin
                  fields_o.op_class = IWD_OP_PTR_STEP;
                  fields_o.ptr_slot = word_i[2];
               end else begin
                  // low bits ignored where unused
                  case (word_i[3:0])
                     4'h8:    fields_o.op_class = IWD_OP_SUB_EXIT;
                     4'h9:    fields_o.op_class = IWD_OP_INT_EXIT;
                     4'ha:    fields_o.op_class = IWD_OP_CSUB_JUMP;
                     4'hb:    fields_o.op_class = IWD_OP_ACC_JUMP;
                     4'h0:    fields_o.op_class = IWD_OP_NOP;
                     default: fields_o.op_class = IWD_OP_CONTROL;
                  endcase
               end
            end
         end
         2'b01: begin
            fields_o.uses_file = 1'b1;
            case (op4[3:2])
               2'b10: begin
                  fields_o.op_class       = IWD_OP_BIT_SKIP_C;
                  fields_o.branch_on_skip = 1'b1;
               end
               2'b11: begin
                  fields_o.op_class       = IWD_OP_BIT_SKIP_S;
                  fields_o.branch_on_skip = 1'b1;
               end
               default: fields_o.op_class = IWD_OP_BIT;
            endcase
         end
         2'b10: begin
            fields_o.literal  = word_i[`IWD_K11_W-1:0];
            fields_o.op_class = word_i[11] ? IWD_OP_ABS_JUMP : IWD_OP_SUB_JUMP;
         end
         default: begin
            fields_o.literal  = {3'h0, word_i[`IWD_K8_W-1:0]};
            fields_o.op_class = IWD_OP_LITERAL;
            if (op4[3:2] == 2'b01) begin
               fields_o.op_class = IWD_OP_EXIT_LIT;
            end else if (op4 == 4'h1 && word_i[7]) begin
               fields_o.op_class = IWD_OP_PAGE_LOAD;
               fields_o.literal  = {4'h0, word_i[`IWD_K7_W-1:0]};
            end else if (op4[3:1] == 3'b001) begin
               fields_o.op_class = IWD_OP_REL_JUMP;
               fields_o.literal  = {2'h0, word_i[`IWD_K9_W-1:0]};
            end else if (op4 == 4'h1) begin
               fields_o.op_class = IWD_OP_PTR_OFFSET;
               fields_o.literal  = {5'h00, word_i[`IWD_K6_W-1:0]};
            end
         end
      endcase
      // unused file index and pointer step dropped so their don't-care bits never show
      if (!fields_o.uses_file) begin
         fields_o.reg_index = '0;
      end
      if (fields_o.op_class != IWD_OP_PTR_STEP) begin
         fields_o.ptr_step = 2'b00;
      end
      case (fields_o.op_class)
         IWD_OP_SUB_JUMP, IWD_OP_CSUB_JUMP, IWD_OP_SUB_EXIT, IWD_OP_EXIT_LIT,
         IWD_OP_INT_EXIT, IWD_OP_ABS_JUMP, IWD_OP_REL_JUMP, IWD_OP_ACC_JUMP:
            fields_o.base_cycles = 2'h2;
         default: fields_o.base_cycles = `IWD_BASE_CYCLES;
      endcase
   end

endmodule

`default_nettype wire

/* File: design/iwd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iwd_cfg.svh"

// Overview of operation
// - one 14-bit word holds opcode and operands
// - one instruction cycle unless listed otherwise
// - subroutine jumps take two cycles
// - returns take two cycles
// - jumps two cycles, skips two when taken
// - indirect access into program memory adds one
// - instruction cycle is four oscillator cycles
// - file operand read, modified, stored
// - file register read even if only written
// - file address spans 0x00 to 0x7f
// - bit field picks one of eight
// - ignored bits never change op class, file index or step field
// - byte ops: target 0 accumulator, 1 file register
// - pointer slot picks pointer 0 or 1
// - step field picks pre/post inc/dec
// - 7-bit file address in low bits
// - pointer offset: slot bit 6, offset 5..0
module iwd_decoder
   import iwd_pkg::*;
#(
   parameter int WORD_W = `IWD_WORD_W
)(
   input  wire logic              clk_sys_i,
   input  wire logic              arst_n_i,
   input  wire logic              word_valid_i,
   input  wire logic [WORD_W-1:0] word_i,
   input  wire logic              indirect_i,
   input  wire logic              ptr_in_prog_i,
   input  wire logic              skip_taken_i,
   input  wire logic [7:0]        file_rdata_i,
   input  wire logic [7:0]        result_i,
   output logic                   word_ready_o,
   output logic                   icyc_stb_o,
   output iwd_fields_t            fields_o,
   output logic                   file_rd_o,
   output logic                   file_wr_o,
   output logic                   acc_wr_o,
   output logic [6:0]             file_addr_o,
   output logic [7:0]             operand_o,
   output logic [7:0]             wdata_o,
   output logic                   busy_o,
   output logic                   done_o
);

   iwd_fields_t fields_w;
   iwd_state_t  state_q;
   iwd_state_t  state_d;
   logic [1:0]  osc_q;
   logic        icyc_stb;
   logic [1:0]  extra_q;
   logic        accept;
   logic        final_cyc;

   iwd_field_split u_split (
      .word_i   (word_i[13:0]),
      .fields_o (fields_w)
   );

   // instruction cycle enable from oscillator divider
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         osc_q <= 2'h0;
      end else begin
         osc_q <= (osc_q == 2'(`IWD_OSC_PER_ICYC - 1)) ? 2'h0 : osc_q + 2'h1;
      end
   end

   assign icyc_stb   = (osc_q == 2'(`IWD_OSC_PER_ICYC - 1));
   assign icyc_stb_o = icyc_stb;
   assign accept     = icyc_stb && word_valid_i && (state_q == IWD_ST_IDLE);
   assign word_ready_o = icyc_stb && (state_q == IWD_ST_IDLE);
   assign final_cyc  = icyc_stb && (extra_q == 2'h0)
                       && (state_q == IWD_ST_READ || state_q == IWD_ST_EXTRA);
   assign busy_o     = (state_q != IWD_ST_IDLE);

   always_comb begin
      state_d = state_q;
      case (state_q)
         IWD_ST_IDLE:  if (accept) state_d = IWD_ST_READ;
         IWD_ST_READ:  if (icyc_stb) state_d = (extra_q == 2'h0
                                                && !(fields_o.branch_on_skip && skip_taken_i))
                                               ? IWD_ST_WRITE : IWD_ST_EXTRA;
         IWD_ST_EXTRA: if (final_cyc) state_d = IWD_ST_WRITE;
         IWD_ST_WRITE: state_d = IWD_ST_IDLE;
         default:      state_d = IWD_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= IWD_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // captured fields for the whole instruction
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fields_o    <= '0;
         file_addr_o <= 7'h00;
      end else if (accept) begin
         fields_o    <= fields_w;
         file_addr_o <= fields_w.reg_index & `IWD_FILE_MAX;
      end
   end

   // remaining instruction cycles beyond the first
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         extra_q <= 2'h0;
      end else if (accept) begin
         extra_q <= fields_w.base_cycles - 2'h1
                    + ((fields_w.uses_file && indirect_i && ptr_in_prog_i)
                       ? 2'h1 : 2'h0);
      end else if (state_q == IWD_ST_READ && icyc_stb) begin
         extra_q <= ((fields_o.branch_on_skip && skip_taken_i)
                     ? extra_q + 2'h1 : extra_q) - ((extra_q != 2'h0 ||
                     (fields_o.branch_on_skip && skip_taken_i)) ? 2'h1 : 2'h0);
      end else if (state_q == IWD_ST_EXTRA && icyc_stb && extra_q != 2'h0) begin
         extra_q <= extra_q - 2'h1;
      end
   end

   // read phase of read-modify-write
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         file_rd_o <= 1'b0;
         operand_o <= 8'h00;
      end else begin
         file_rd_o <= accept && fields_w.uses_file;
         if (file_rd_o) begin
            operand_o <= file_rdata_i;
         end
      end
   end

   // write phase, steered by target_sel for byte ops only
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         file_wr_o <= 1'b0;
         acc_wr_o  <= 1'b0;
         wdata_o   <= 8'h00;
         done_o    <= 1'b0;
      end else begin
         done_o    <= (state_d == IWD_ST_WRITE) && (state_q != IWD_ST_WRITE);
         file_wr_o <= 1'b0;
         acc_wr_o  <= 1'b0;
         if ((state_d == IWD_ST_WRITE) && (state_q != IWD_ST_WRITE)
             && fields_o.uses_file) begin
            wdata_o <= result_i;
            case (fields_o.op_class)
               IWD_OP_BYTE_SKIP, IWD_OP_BYTE: begin
                  file_wr_o <= fields_o.target_sel;
                  acc_wr_o  <= ~fields_o.target_sel;
               end
               IWD_OP_BIT, IWD_OP_MOVE_W, IWD_OP_CLEAR:
                  file_wr_o <= 1'b1;
               default: begin
                  file_wr_o <= 1'b0;
                  acc_wr_o  <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

/* File: testbench/iwd_decoder_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module iwd_decoder_chk
   import iwd_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        arst_n_i,
   input wire logic        word_valid_i,
   input wire logic        word_ready_o,
   input wire logic        icyc_stb_o,
   input wire logic        busy_o,
   input wire logic        file_rd_o,
   input wire logic        file_wr_o,
   input wire logic        acc_wr_o,
   input wire logic [6:0]  file_addr_o,
   input wire iwd_fields_t fields_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   logic take;
   assign take = icyc_stb_o && word_ready_o && word_valid_i;
   sequence s_accept;
      take;
   endsequence
   sequence s_gap;
      !icyc_stb_o [*3] ##1 icyc_stb_o;
   endsequence
   a_osc_period: assert property (icyc_stb_o |=> s_gap)
      else $error("strobe spacing wrong");
   a_ready_idle: assert property (word_ready_o |-> icyc_stb_o && !busy_o)
      else $error("ready while busy or off strobe");
   a_busy_span: assert property (s_accept |=> busy_o [*3])
      else $error("instruction shorter than one cycle");
   a_read_follow: assert property (s_accept |=> file_rd_o == fields_o.uses_file)
      else $error("file read missing after accept");
   a_addr_match: assert property (file_rd_o |-> file_addr_o == fields_o.reg_index)
      else $error("file address differs from field");
   a_acc_target: assert property (acc_wr_o |-> !fields_o.target_sel)
      else $error("accumulator write with target 1");
   a_byte_dest: assert property (file_wr_o && fields_o.op_class == IWD_OP_BYTE
      |-> fields_o.target_sel)
      else $error("file write with target 0");
   a_fields_hold: assert property (!take |=> $stable(fields_o))
      else $error("fields changed without accept");
endmodule
bind iwd_decoder iwd_decoder_chk chk_u (
   .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .word_valid_i(word_valid_i),
   .word_ready_o(word_ready_o), .icyc_stb_o(icyc_stb_o), .busy_o(busy_o),
   .file_rd_o(file_rd_o), .file_wr_o(file_wr_o), .acc_wr_o(acc_wr_o),
   .file_addr_o(file_addr_o), .fields_o(fields_o)
);
`default_nettype wire

/* File: testbench/iwd_fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module iwd_fetch_model (
   input  wire logic        clk_sys_i,
   input  wire logic        arst_n_i,
   input  wire logic        req_i,
   input  wire logic [13:0] req_word_i,
   input  wire logic        word_ready_i,
   input  wire logic        icyc_stb_i,
   output logic             word_valid_o,
   output logic [13:0]      word_o
);
   logic [13:0] word_q;
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         word_valid_o <= 1'b0;
         word_q       <= 14'h0000;
      end else if (req_i && !word_valid_o) begin
         word_valid_o <= 1'b1;
         word_q       <= req_word_i;
      end else if (word_valid_o && icyc_stb_i && word_ready_i) begin
         word_valid_o <= 1'b0;
      end
   end
   // released bus shows inverse of last word
   assign word_o = word_valid_o ? word_q : ~word_q;
endmodule
`default_nettype wire

/* File: testbench/iwd_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import iwd_pkg::*;
   logic clk_sys_i = 1'b0, arst_n_i = 1'b0, req = 1'b0, word_valid_i;
   logic indirect_i = 1'b0, ptr_in_prog_i = 1'b0, skip_taken_i = 1'b0;
   logic [13:0] req_word = 14'h0000, word_i;
   logic [7:0]  file_rdata_i = 8'h00, result_i = 8'h00, operand_o, wdata_o;
   logic word_ready_o, icyc_stb_o, file_rd_o, file_wr_o, acc_wr_o, busy_o, done_o, rd, aw, fw;
   logic [6:0]  file_addr_o;
   iwd_fields_t fields_o, keep;
   int fail_count = 0, num_checks = 0, cyc = 0, base, dur;
   always #25 clk_sys_i = ~clk_sys_i;
   iwd_fetch_model fetch_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .req_i(req),
      .req_word_i(req_word), .word_ready_i(word_ready_o), .icyc_stb_i(icyc_stb_o),
      .word_valid_o(word_valid_i), .word_o(word_i));
   iwd_decoder dut_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .word_valid_i(word_valid_i),
      .word_i(word_i), .indirect_i(indirect_i), .ptr_in_prog_i(ptr_in_prog_i),
      .skip_taken_i(skip_taken_i), .file_rdata_i(file_rdata_i), .result_i(result_i),
      .word_ready_o(word_ready_o), .icyc_stb_o(icyc_stb_o), .fields_o(fields_o),
      .file_rd_o(file_rd_o), .file_wr_o(file_wr_o), .acc_wr_o(acc_wr_o),
      .file_addr_o(file_addr_o), .operand_o(operand_o), .wdata_o(wdata_o),
      .busy_o(busy_o), .done_o(done_o));
   task complete_run;
      if (fail_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task check(input string name, input logic [39:0] seen, input logic [39:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task run(input logic [13:0] w, input logic ind, input logic prg, input logic skp);
      logic hit;
      int n;
      n = 0;
      @(posedge clk_sys_i);
      req <= 1'b1;
      req_word <= w;
      indirect_i <= ind;
      ptr_in_prog_i <= prg;
      skip_taken_i <= skp;
      file_rdata_i <= w[7:0] ^ 8'h5a;
      result_i <= ~w[7:0];
      do begin
         @(negedge clk_sys_i);
         hit = icyc_stb_o && word_ready_o && word_valid_i;
         @(posedge clk_sys_i) req <= 1'b0;
         n++;
      end while (!hit && n < 40);
      @(negedge clk_sys_i);
      rd = file_rd_o;
      aw = acc_wr_o;
      fw = file_wr_o;
      dur = 1;
      while (done_o !== 1'b1 && dur < 60) begin
         @(negedge clk_sys_i);
         dur++;
         aw = aw | acc_wr_o;
         fw = fw | file_wr_o;
      end
      check("finish", {hit, dur < 60}, 2'b11);
      if (rd === 1'b1)
         check("operand", operand_o, w[7:0] ^ 8'h5a);
   endtask
   task t_byte;
      run(14'h07ff, 1'b0, 1'b0, 1'b0);
      base = dur;
      check("index", fields_o.reg_index, 7'h7f);
      check("addr", file_addr_o, 7'h7f);
      check("dest_f", {fields_o.target_sel, fw, aw}, 3'b110);
      check("wdata", wdata_o, 8'h00);
      run(14'h0700, 1'b0, 1'b0, 1'b0);
      check("dest_w", {fields_o.target_sel, fw, aw}, 3'b001);
      check("index0", fields_o.reg_index, 7'h00);
      check("wdata_ff", wdata_o, 8'hff);
      check("one_cyc", dur, base);
   endtask
   task t_skip;
      run(14'h1e92, 1'b0, 1'b0, 1'b0);
      check("bitpos", {fields_o.pos_in_octet, fields_o.reg_index}, {3'h5, 7'h12});
      check("no_skip", dur, base);
      run(14'h1e92, 1'b0, 1'b0, 1'b1);
      check("bit_skip", dur, base + 4);
      run(14'h1bff, 1'b0, 1'b0, 1'b1);
      check("bitpos7", fields_o.pos_in_octet, 3'h7);
      check("clr_skip", dur, base + 4);
      run(14'h0b81, 1'b0, 1'b0, 1'b1);
      check("dec_skip", dur, base + 4);
   endtask
   task t_ind;
      run(14'h07ff, 1'b1, 1'b1, 1'b0);
      check("ind_prog", dur, base + 4);
      run(14'h07ff, 1'b1, 1'b0, 1'b0);
      check("ind_data", dur, base);
   endtask
   task t_lit;
      run(14'h30a5, 1'b0, 1'b0, 1'b0);
      check("lit8", {rd, fields_o.literal[7:0]}, 9'h0a5);
      run(14'h0035, 1'b0, 1'b0, 1'b0);
      check("lit5", fields_o.literal[4:0], 5'h15);
      run(14'h31d5, 1'b0, 1'b0, 1'b0);
      check("lit7", fields_o.literal[6:0], 7'h55);
      run(14'h00aa, 1'b0, 1'b0, 1'b0);
      check("wr_only", {rd, fields_o.reg_index}, 8'haa);
   endtask
   task t_ign;
      run(14'h0100, 1'b0, 1'b0, 1'b0);
      keep = fields_o;
      run(14'h0103, 1'b0, 1'b0, 1'b0);
      check("ignored", fields_o, keep);
   endtask
   task t_ctrl;
      run(14'h2d55, 1'b0, 1'b0, 1'b0);
      check("lit11", fields_o.literal, 11'h555);
      check("absolute_jump_cyc", dur, base + 4);
      run(14'h2123, 1'b0, 1'b0, 1'b0);
      check("call", {fields_o.op_class, fields_o.literal}, {IWD_OP_SUB_JUMP, 11'h123});
      check("call_cyc", dur, base + 4);
      run(14'h000a, 1'b0, 1'b0, 1'b0);
      check("ccall_cyc", dur, base + 4);
      run(14'h0008, 1'b0, 1'b0, 1'b0);
      check("ret_cyc", dur, base + 4);
      run(14'h0009, 1'b0, 1'b0, 1'b0);
      check("iret_cyc", dur, base + 4);
      run(14'h3412, 1'b0, 1'b0, 1'b0);
      check("lret_cyc", dur, base + 4);
      run(14'h3345, 1'b0, 1'b0, 1'b0);
      check("lit9", fields_o.literal[8:0], 9'h145);
      check("rel_cyc", dur, base + 4);
      run(14'h000b, 1'b0, 1'b0, 1'b0);
      check("accj_cyc", dur, base + 4);
      run(14'h3165, 1'b0, 1'b0, 1'b0);
      check("ptr_off", {fields_o.ptr_slot, fields_o.literal[5:0]}, 7'h65);
      check("ptr_off_cyc", dur, base);
      run(14'h0016, 1'b0, 1'b0, 1'b0);
      check("ptr_step1", {fields_o.ptr_slot, fields_o.ptr_step}, 3'b110);
      run(14'h0013, 1'b0, 1'b0, 1'b0);
      check("ptr_step0", {fields_o.ptr_slot, fields_o.ptr_step}, 3'b011);
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      repeat (4) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      t_byte();
      t_skip();
      t_ind();
      t_lit();
      t_ign();
      t_ctrl();
      complete_run();
   end
endmodule
`default_nettype wire
